//--- rtl/mq_pkg.sv
`default_nettype none
package mq_pkg;
  localparam int QUEUES       = 4;
  localparam int QUEUE_BITS   = 2;
  localparam int DEVICE_BITS  = 3;
  localparam int DATA_W       = 36;
  localparam int QUEUE_DEPTH  = 16;
  localparam int FIFO_DEPTH   = 8;
  localparam int AF_MARGIN    = 2;
  localparam int AE_MARGIN    = 2;
  localparam int ADDR_W       = DEVICE_BITS + QUEUE_BITS;

  typedef enum logic [1:0] {
    PH_RUN = 2'h0,
    PH_OLD = 2'h1,
    PH_NEW = 2'h2
  } sel_phase_type;

  typedef struct packed {
    logic [QUEUE_BITS-1:0] queue;
    logic                  last;
    logic [DATA_W-1:0]     data;
  } wr_req_type;
endpackage
`default_nettype wire

//--- rtl/multiqueue_read_select_and_flags.sv
`default_nettype none

module mq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wptr_ff;
  logic [PW-1:0]    rptr_ff;
  logic [PW:0]      cnt_ff;
  logic             push;
  logic             pop;

  if (DEPTH < 2 || (1 << PW) != DEPTH)
  begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  assign in_ready  = (cnt_ff != (PW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rptr_ff];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wptr_ff] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff  <= '0;
    end
    else
    begin
      if (push)
        wptr_ff <= wptr_ff + 1'b1;
      if (pop)
        rptr_ff <= rptr_ff + 1'b1;
      if (push && !pop)
        cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule

module multiqueue_read_select_and_flags #(
  parameter int                         DEPTH     = mq_pkg::QUEUE_DEPTH,
  parameter logic [mq_pkg::DEVICE_BITS-1:0] DEVICE_ID = 3'h0
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        wr_sel,
  input  wire logic [mq_pkg::ADDR_W-1:0]   wr_addr,
  input  wire logic                        wr_en_low,
  input  wire logic [mq_pkg::DATA_W-1:0]   wr_data,
  input  wire logic                        wr_last,
  output logic                             wr_ready,
  input  wire logic                        wr_commit_hold,
  input  wire logic                        packet_mode,
  input  wire logic                        rd_sel,
  input  wire logic [mq_pkg::ADDR_W-1:0]   rd_addr,
  input  wire logic                        rd_null,
  input  wire logic                        rd_en_low,
  input  wire logic                        oe_low,
  input  wire logic                        expansion_take_in,
  output logic                             expansion_take_out,
  output logic [mq_pkg::DATA_W-1:0]        data_out,
  output logic                             data_out_oe,
  output logic                             output_valid_low,
  output logic                             output_valid_oe,
  output logic                             full_flag_low,
  output logic                             full_flag_oe,
  output logic                             almost_full_flag_low,
  output logic                             almost_empty_flag_low,
  output logic                             packet_ready_low
);
  import mq_pkg::*;
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW:0] AF_CNT   = (PW+1)'(DEPTH - AF_MARGIN);
  localparam logic [PW:0] AE_CNT   = (PW+1)'(AE_MARGIN);
  localparam logic [PW:0] ONE_CNT  = (PW+1)'(1);

  if (DEPTH < 4 || (1 << PW) != DEPTH || DEPTH <= AF_MARGIN)
  begin : g_bad_depth
    $error("queue depth must be a power of two above the flag margins");
  end

  logic [DATA_W-1:0]     mem      [QUEUES*DEPTH];
  logic                  mem_last [QUEUES*DEPTH];
  logic [PW-1:0]         wptr_ff  [QUEUES];
  logic [PW-1:0]         rptr_ff  [QUEUES];
  logic [PW:0]           res_ff   [QUEUES];
  logic [PW:0]           com_ff   [QUEUES];
  logic [PW:0]           pkt_ff   [QUEUES];
  logic [PW:0]           nxt_res  [QUEUES];
  logic [QUEUES-1:0]     avail;
  logic [QUEUE_BITS-1:0] wq_ff;
  logic                  wq_mine_ff;
  logic [QUEUE_BITS-1:0] nxt_wq;
  logic                  nxt_wq_mine;
  logic [QUEUE_BITS-1:0] rq_ff;
  logic                  rq_mine_ff;
  logic                  rq_null_ff;
  logic [QUEUE_BITS-1:0] pend_q_ff;
  logic                  pend_mine_ff;
  logic                  pend_null_ff;
  sel_phase_type         phase_ff;
  logic                  rq_ok;
  logic                  rd_do;
  logic                  accept;
  logic                  drain;
  logic                  fifo_valid;
  wr_req_type            fifo_in;
  wr_req_type            fifo_out;
  logic [DATA_W-1:0]     data_ff;
  logic                  ov_low_ff;
  logic                  empty_after_ff;
  logic                  owner_ff;
  logic                  take_ff;
  logic                  full_low_ff;
  logic                  af_raw;
  logic                  af_s1_ff;
  logic                  af_low_ff;
  logic                  ae_raw;
  logic                  ae_s1_ff;
  logic                  ae_low_ff;
  logic                  pr_low_ff;

  // writes are reserved against the queue on entry to the buffer, so full is exact
  assign accept  = !wr_en_low && full_low_ff && wq_mine_ff && wr_ready;
  assign fifo_in = '{queue: wq_ff, last: wr_last, data: wr_data};
  assign drain   = fifo_valid && !wr_commit_hold;

  mq_fifo #(
    .WIDTH ($bits(wr_req_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (accept),
    .in_ready  (wr_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_valid),
    .out_ready (!wr_commit_hold),
    .out_data  (fifo_out)
  );

  assign nxt_wq      = wr_sel ? wr_addr[QUEUE_BITS-1:0] : wq_ff;
  assign nxt_wq_mine = wr_sel ? (wr_addr[ADDR_W-1:QUEUE_BITS] == DEVICE_ID) : wq_mine_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wq_ff      <= '0;
      wq_mine_ff <= 1'b0;
    end
    else
    begin
      wq_ff      <= nxt_wq;
      wq_mine_ff <= nxt_wq_mine;
    end
  end

  // the read path: selection pipeline, one word per cycle at most
  assign rq_ok = rq_mine_ff && !rq_null_ff;
  always_comb
  begin
    rd_do = 1'b0;
    unique case (phase_ff)
      PH_RUN: rd_do = rq_ok && avail[rq_ff] && (!rd_en_low || ov_low_ff);
      PH_OLD: rd_do = rq_ok && avail[rq_ff];
      PH_NEW: rd_do = rq_ok && avail[rq_ff];
      default: rd_do = 1'b0;
    endcase
  end

  for (genvar i = 0; i < QUEUES; i++)
  begin : g_queue
    logic inc_res;
    logic inc_com;
    logic dec;
    logic pkt_in;
    logic pkt_out;
    assign inc_res = accept && (wq_ff == QUEUE_BITS'(i));
    assign inc_com = drain && (fifo_out.queue == QUEUE_BITS'(i));
    assign dec     = rd_do && (rq_ff == QUEUE_BITS'(i));
    assign pkt_in  = inc_com && fifo_out.last;
    assign pkt_out = dec && mem_last[i*DEPTH + int'(rptr_ff[i])];
    assign nxt_res[i] = res_ff[i] + (PW+1)'(inc_res) - (PW+1)'(dec);
    assign avail[i] = (com_ff[i] != '0) && (!packet_mode || pkt_ff[i] != '0);

    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        wptr_ff[i] <= '0;
        rptr_ff[i] <= '0;
        res_ff[i]  <= '0;
        com_ff[i]  <= '0;
        pkt_ff[i]  <= '0;
      end
      else
      begin
        res_ff[i] <= nxt_res[i];
        com_ff[i] <= com_ff[i] + (PW+1)'(inc_com) - (PW+1)'(dec);
        pkt_ff[i] <= pkt_ff[i] + (PW+1)'(pkt_in) - (PW+1)'(pkt_out);
        if (inc_com)
          wptr_ff[i] <= wptr_ff[i] + 1'b1;
        if (dec)
          rptr_ff[i] <= rptr_ff[i] + 1'b1;
      end
    end

    always_ff @(posedge clk)
    begin
      if (inc_com)
      begin
        mem[i*DEPTH + int'(wptr_ff[i])]      <= fifo_out.data;
        mem_last[i*DEPTH + int'(wptr_ff[i])] <= fifo_out.last;
      end
    end
  end

  // selections arriving outside the run phase are dropped; spacing is the host's job
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      phase_ff     <= PH_RUN;
      rq_ff        <= '0;
      rq_mine_ff   <= 1'b0;
      rq_null_ff   <= 1'b1;
      pend_q_ff    <= '0;
      pend_mine_ff <= 1'b0;
      pend_null_ff <= 1'b1;
    end
    else
    begin
      unique case (phase_ff)
        PH_RUN:
        begin
          if (rd_sel)
          begin
            pend_q_ff    <= rd_addr[QUEUE_BITS-1:0];
            pend_mine_ff <= (rd_addr[ADDR_W-1:QUEUE_BITS] == DEVICE_ID);
            pend_null_ff <= rd_null;
            phase_ff     <= PH_OLD;
          end
        end
        PH_OLD:
        begin
          rq_ff      <= pend_q_ff;
          rq_mine_ff <= pend_mine_ff;
          rq_null_ff <= pend_null_ff;
          phase_ff   <= PH_NEW;
        end
        PH_NEW:
          phase_ff <= PH_RUN;
        default:
          phase_ff <= PH_RUN;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      data_ff <= '0;
    else if (rd_do)
      data_ff <= mem[int'(rq_ff)*DEPTH + int'(rptr_ff[rq_ff])];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ov_low_ff      <= 1'b1;
      empty_after_ff <= 1'b0;
    end
    else
    begin
      // a commit landing on the same edge keeps the queue non-empty
      empty_after_ff <= rd_do && (com_ff[rq_ff] == ONE_CNT)
                        && !(drain && fifo_out.queue == rq_ff);
      if (rd_do)
        ov_low_ff <= 1'b0;
      else if (empty_after_ff)
        ov_low_ff <= 1'b1;
      else if (phase_ff == PH_NEW || (phase_ff == PH_RUN && !rd_en_low))
        ov_low_ff <= 1'b1;
    end
  end

  // bus ownership passes to whichever device last delivered a word
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      owner_ff <= 1'b0;
      take_ff  <= 1'b0;
    end
    else
    begin
      take_ff <= rd_do;
      if (rd_do)
        owner_ff <= 1'b1;
      else if (expansion_take_in)
        owner_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      full_low_ff <= 1'b1;
      af_s1_ff    <= 1'b1;
      af_low_ff   <= 1'b1;
      ae_s1_ff    <= 1'b1;
      ae_low_ff   <= 1'b1;
      pr_low_ff   <= 1'b1;
    end
    else
    begin
      full_low_ff <= (nxt_res[nxt_wq] != FULL_CNT);
      af_s1_ff    <= af_raw;
      af_low_ff   <= af_s1_ff;
      ae_s1_ff    <= ae_raw;
      ae_low_ff   <= ae_s1_ff;
      pr_low_ff   <= !(rq_ok && pkt_ff[rq_ff] != '0);
    end
  end

  assign af_raw = (res_ff[wq_ff] < AF_CNT);
  assign ae_raw = !rq_ok || (com_ff[rq_ff] > AE_CNT);

  // output enable is deliberately unclocked; expansion shares it across devices
  assign data_out_oe           = !oe_low && owner_ff;
  assign output_valid_oe       = owner_ff;
  assign full_flag_oe          = wq_mine_ff;
  assign data_out              = data_ff;
  assign output_valid_low      = ov_low_ff;
  assign full_flag_low         = full_low_ff;
  assign almost_full_flag_low  = af_low_ff;
  assign almost_empty_flag_low = ae_low_ff;
  assign packet_ready_low      = pr_low_ff;
  assign expansion_take_out    = take_ff;

  a_full_blocks_write: assert property (@(posedge clk) disable iff (!rst_n)
    !full_flag_low |-> !accept) else $error("write taken while full");
  a_old_queue_read: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_ff == PH_OLD && rq_ok && avail[rq_ff]) |=> !output_valid_low
    && data_out == $past(mem[int'(rq_ff)*DEPTH + int'(rptr_ff[rq_ff])]))
    else $error("old queue word missing after select");
  a_new_queue_word: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_ff == PH_RUN && rd_sel && !rd_null
     && rd_addr[ADDR_W-1:QUEUE_BITS] == DEVICE_ID) |-> ##2 (phase_ff == PH_NEW
     && rq_ff == $past(rd_addr[QUEUE_BITS-1:0], 2)))
    else $error("new queue not presented two cycles after select");
  a_hold_word: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_ff == PH_RUN && rd_en_low && !output_valid_low) |=> $stable(data_out))
    else $error("output word changed with reads disabled");
  a_ov_after_empty: assert property (@(posedge clk) disable iff (!rst_n)
    (empty_after_ff && !rd_do) |=> output_valid_low && $stable(data_out))
    else $error("valid not released after last word");
  a_null_is_empty: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_ff == PH_NEW && rq_null_ff) |=> output_valid_low && $stable(data_out))
    else $error("null queue refilled output");
  a_af_latency: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n, 2) |-> almost_full_flag_low == $past(af_raw, 2))
    else $error("almost full latency wrong");
  a_ae_latency: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n, 2) |-> almost_empty_flag_low == $past(ae_raw, 2))
    else $error("almost empty latency wrong");
  a_packet_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (packet_mode && pkt_ff[rq_ff] == '0) |-> !rd_do)
    else $error("read before packet complete");
  a_first_word_fallthrough_frees_full: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_do && !wr_sel && rq_ff == wq_ff && wq_mine_ff && res_ff[rq_ff] == FULL_CNT)
    |=> full_flag_low) else $error("read did not release full");
  a_bus_handover: assert property (@(posedge clk) disable iff (!rst_n)
    (expansion_take_in && !rd_do) |=> !output_valid_oe && !data_out_oe)
    else $error("bus not released to other device");
endmodule
`default_nettype wire

//--- testbench/mq_host.sv
`default_nettype none
module mq_host (
  input  wire logic                 clk,
  output logic                      wr_sel,
  output logic [mq_pkg::ADDR_W-1:0] wr_addr,
  output logic                      wr_en_low,
  output logic [mq_pkg::DATA_W-1:0] wr_data,
  output logic                      wr_last,
  output logic                      rd_sel,
  output logic [mq_pkg::ADDR_W-1:0] rd_addr,
  output logic                      rd_null,
  output logic                      expansion_take_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import mq_pkg::*;

  int since_sel = 9;

  initial
  begin
    wr_sel = 1'b0;
    wr_addr = 5'h1F;
    wr_en_low = 1'b1;
    wr_data = 36'h0;
    wr_last = 1'b0;
    rd_sel = 1'b0;
    rd_addr = 5'h1F;
    rd_null = 1'b0;
    expansion_take_in = 1'b0;
  end

  always @(posedge clk)
    since_sel <= rd_sel ? 0 : since_sel + 1;

  // all tasks are entered just after a falling edge
  task automatic wsel(input logic [ADDR_W-1:0] a);
    wr_sel = 1'b1;
    wr_addr = a;
    @(negedge clk);
    wr_sel = 1'b0;
    wr_addr = ~a;
    @(negedge clk);
  endtask

  // held low across back-to-back calls; wr_stop releases
  task automatic wr(input logic [DATA_W-1:0] d, input logic l);
    wr_en_low = 1'b0;
    wr_data = d;
    wr_last = l;
    @(negedge clk);
  endtask

  task automatic wr_stop();
    wr_en_low = 1'b1;
    wr_data = ~wr_data;
    wr_last = 1'b0;
  endtask

  task automatic rsel(input logic [ADDR_W-1:0] a, input logic n);
    while (since_sel < 2) @(negedge clk);
    rd_sel = 1'b1;
    rd_addr = a;
    rd_null = n;
    @(negedge clk);
    rd_sel = 1'b0;
    rd_addr = ~a;
    rd_null = 1'b0;
  endtask

  // another device in the bank has just delivered a word
  task automatic peer_take();
    expansion_take_in = 1'b1;
    @(negedge clk);
    expansion_take_in = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench/multiqueue_read_select_and_flags_bench.sv
`default_nettype none
module multiqueue_read_select_and_flags_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mq_pkg::*;

  localparam int DEP = 8;

  logic              clk, rst_n, rd_en_low, packet_mode, wr_commit_hold;
  logic              oe_low;
  logic              expansion_take_in, expansion_take_out, wr_ready;
  logic              wr_sel, wr_en_low, wr_last, rd_sel, rd_null;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [DATA_W-1:0] wr_data, data_out;
  logic              data_out_oe, output_valid_low, output_valid_oe;
  logic              full_flag_low, full_flag_oe, almost_full_flag_low;
  logic              almost_empty_flag_low, packet_ready_low, took;
  int                err_total, checks_done, i, n, pr_at, ov_at;

  multiqueue_read_select_and_flags #(
    .DEPTH     (DEP),
    .DEVICE_ID (3'h0)
  ) u_multiqueue_read_select_and_flags (
    .clk, .rst_n, .wr_sel, .wr_addr, .wr_en_low, .wr_data, .wr_last,
    .wr_ready, .wr_commit_hold, .packet_mode, .rd_sel, .rd_addr, .rd_null,
    .rd_en_low, .oe_low, .expansion_take_in, .expansion_take_out, .data_out,
    .data_out_oe, .output_valid_low, .output_valid_oe, .full_flag_low,
    .full_flag_oe, .almost_full_flag_low, .almost_empty_flag_low,
    .packet_ready_low
  );

  mq_host u_mq_host (
    .clk, .wr_sel, .wr_addr, .wr_en_low, .wr_data, .wr_last,
    .rd_sel, .rd_addr, .rd_null, .expansion_take_in
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [35:0] wd(input int q, input int k);
    return {28'hA5A5A5A, q[3:0], k[3:0]};
  endfunction

  task automatic tick(input int c);
    repeat (c) @(negedge clk);
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // far more than the sequence needs
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    end_sim();
  end

  initial
  begin
    err_total = 0;
    checks_done = 0;
    rd_en_low = 1'b1;
    oe_low = 1'b0;
    packet_mode = 1'b0;
    wr_commit_hold = 1'b0;
    rst_n = 1'b0;
    tick(16);
    rst_n = 1'b1;
    chk(output_valid_low, 1'b1);
    chk(full_flag_oe, 1'b0);
    u_mq_host.wsel(5'h00);
    chk(full_flag_oe, 1'b1);
    for (i = 0; i < 3; i++) u_mq_host.wr(wd(0, i), 1'b0);
    u_mq_host.wr_stop();
    tick(2);
    u_mq_host.rsel(5'h00, 1'b0);
    chk(output_valid_low, 1'b1);
    tick(1);
    chk(output_valid_low, 1'b1);
    tick(1);
    chk(data_out, wd(0, 0));
    chk(output_valid_low, 1'b0);
    chk(data_out_oe, 1'b1);
    #1 oe_low = 1'b1;
    #1 chk(data_out_oe, 1'b0);
    oe_low = 1'b0;
    tick(3);
    chk(data_out, wd(0, 0));
    rd_en_low = 1'b0;
    tick(1);
    chk(data_out, wd(0, 1));
    tick(1);
    rd_en_low = 1'b1;
    chk(data_out, wd(0, 2));
    tick(1);
    chk(output_valid_low, 1'b1);
    chk(data_out, wd(0, 2));
    u_mq_host.wr(wd(0, 3), 1'b0);
    u_mq_host.wr_stop();
    n = 0;
    while (output_valid_low !== 1'b0 && n < 8)
    begin
      tick(1);
      n++;
    end
    chk(data_out, wd(0, 3));
    chk(n < 4, 1'b1);
    tick(3);
    chk(almost_empty_flag_low, 1'b0);
    // hold the drain so the write buffer itself fills up
    u_mq_host.wsel(5'h01);
    wr_commit_hold = 1'b1;
    for (i = 0; i < 8; i++) u_mq_host.wr(wd(1, i), 1'b0);
    chk(wr_ready, 1'b0);
    u_mq_host.wr(wd(1, 9), 1'b0);
    u_mq_host.wr_stop();
    chk(full_flag_low, 1'b0);
    chk(almost_full_flag_low, 1'b0);
    wr_commit_hold = 1'b0;
    tick(12);
    chk(wr_ready, 1'b1);
    chk(full_flag_low, 1'b0);
    u_mq_host.rsel(5'h01, 1'b0);
    tick(2);
    chk(data_out, wd(1, 0));
    tick(2);
    chk(full_flag_low, 1'b1);
    chk(almost_empty_flag_low, 1'b1);
    u_mq_host.wsel(5'h02);
    tick(2);
    chk(almost_full_flag_low, 1'b1);
    u_mq_host.wr(wd(2, 0), 1'b0);
    u_mq_host.wr(wd(2, 1), 1'b0);
    u_mq_host.wr_stop();
    u_mq_host.wsel(5'h04);
    chk(full_flag_oe, 1'b0);
    tick(2);
    u_mq_host.rsel(5'h02, 1'b0);
    tick(1);
    chk(data_out, wd(1, 1));
    tick(1);
    chk(data_out, wd(2, 0));
    tick(1);
    u_mq_host.rsel(5'h00, 1'b1);
    tick(1);
    chk(data_out, wd(2, 1));
    tick(1);
    chk(output_valid_low, 1'b1);
    tick(2);
    chk(data_out, wd(2, 1));
    chk(almost_empty_flag_low, 1'b1);
    packet_mode = 1'b1;
    u_mq_host.wsel(5'h03);
    u_mq_host.wr(wd(3, 0), 1'b0);
    u_mq_host.wr(wd(3, 1), 1'b0);
    u_mq_host.wr_stop();
    u_mq_host.rsel(5'h03, 1'b0);
    u_mq_host.peer_take();
    tick(4);
    chk(output_valid_low, 1'b1);
    chk(packet_ready_low, 1'b1);
    chk(output_valid_oe, 1'b0);
    chk(data_out_oe, 1'b0);
    pr_at = -1;
    ov_at = -1;
    took = 1'b0;
    u_mq_host.wr(wd(3, 2), 1'b1);
    u_mq_host.wr_stop();
    for (i = 0; i < 12; i++)
    begin
      tick(1);
      if (pr_at < 0 && packet_ready_low === 1'b0) pr_at = i;
      if (ov_at < 0 && output_valid_low === 1'b0) ov_at = i;
      if (expansion_take_out === 1'b1) took = 1'b1;
    end
    chk(pr_at >= 0 && pr_at <= ov_at && ov_at <= pr_at + 1, 1'b1);
    chk(data_out, wd(3, 0));
    chk(output_valid_oe, 1'b1);
    chk(took, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
